/* core/spcg_clock_gen.sv */
/*
 clock generation unit of the serial port: baud generator, slave clock sync,
 transmit/receive base clocks and transfer clock pin control, apb registers.
 assumes an apb master on I_CLK and the transfer clock pin driven outside.
*/
`default_nettype none
module spcg_clock_gen
    import spcg_pkg::*;
#(
    parameter int DIV_WIDTH = 12
)
(
    input wire logic I_CLK,
    input wire logic I_RST_N,
    input wire logic I_PSEL,
    input wire logic I_PENABLE,
    input wire logic I_PWRITE,
    input wire logic [7:0] I_PADDR,
    input wire logic [31:0] I_PWDATA,
    output logic [31:0] O_PRDATA,
    output logic O_PREADY,
    output logic O_PSLVERR,
    input wire logic I_XCK_IN,
    output logic O_XCK_OUT,
    output logic O_XCK_OE,
    output logic O_TXCLK,
    output logic O_RXCLK,
    output logic O_CHANGE_EDGE,
    output logic O_SAMPLE_EDGE
);
    initial
    begin
        if (DIV_WIDTH != 12)
        begin
            $error("divisor width must be 12");
        end
        if (SPCG_SYNC_STAGES != 2)
        begin
            $error("synchroniser must have two stages");
        end
    end

    typedef struct packed {
        logic [4:0] ctrl;
        logic [DIV_WIDTH-1:0] div;
        logic [DIV_WIDTH-1:0] cnt;
        logic [SPCG_SYNC_STAGES-1:0] xsync;
        logic xprev;
        logic [3:0] txdiv;
        logic [3:0] rxstate;
        logic xck_out;
        logic xck_oe;
        logic txclk;
        logic rxclk;
        logic change_edge;
        logic sample_edge;
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
    } spcg_state_t;

    spcg_state_t st_ff;
    spcg_state_t nxt_st;
    spcg_apb_req_t req;
    spcg_mode_t mode;
    logic gen_pulse;
    logic ext_rise;
    logic ext_fall;
    logic clk_rise;
    logic clk_fall;
    logic [3:0] tx_last;
    logic [3:0] rx_last;

    function automatic logic [3:0] last_count(input spcg_mode_t m);
        case (m)
            SPCG_MODE_ASYNC: last_count = 4'(SPCG_DIV_NORMAL - 1);
            SPCG_MODE_DOUBLE: last_count = 4'(SPCG_DIV_DOUBLE - 1);
            default: last_count = 4'(SPCG_DIV_SYNC - 1);
        endcase
    endfunction

    assign req = '{psel: I_PSEL, penable: I_PENABLE, pwrite: I_PWRITE,
                   paddr: I_PADDR, pwdata: I_PWDATA};

    always_comb
    begin
        if (!st_ff.ctrl[SPCG_BIT_SYNC_SEL])
        begin
            mode = st_ff.ctrl[SPCG_BIT_DOUBLE] ? SPCG_MODE_DOUBLE : SPCG_MODE_ASYNC;
        end
        else if (st_ff.ctrl[SPCG_BIT_PIN_DIR])
        begin
            mode = SPCG_MODE_MASTER;
        end
        else
        begin
            mode = SPCG_MODE_SLAVE;
        end
    end

    assign tx_last = last_count(mode);
    assign rx_last = last_count(mode);
    assign gen_pulse = (st_ff.cnt == '0) && (mode != SPCG_MODE_SLAVE)
        && !st_ff.ctrl[SPCG_BIT_POWER_RED];
    assign ext_rise = st_ff.xsync[1] && !st_ff.xprev;
    assign ext_fall = !st_ff.xsync[1] && st_ff.xprev;

    always_comb
    begin
        nxt_st = st_ff;
        nxt_st.pready = 1'b0;
        nxt_st.pslverr = 1'b0;
        nxt_st.txclk = 1'b0;
        nxt_st.rxclk = 1'b0;
        nxt_st.change_edge = 1'b0;
        nxt_st.sample_edge = 1'b0;
        clk_rise = 1'b0;
        clk_fall = 1'b0;
        // synchroniser samples the pin in every mode, edge history kept only in slave mode
        nxt_st.xsync = {st_ff.xsync[0], I_XCK_IN};
        nxt_st.xprev = (mode == SPCG_MODE_SLAVE) ? st_ff.xsync[1] : 1'b0;
        // baud down-counter
        if (st_ff.cnt == '0)
        begin
            nxt_st.cnt = st_ff.div;
        end
        else
        begin
            nxt_st.cnt = st_ff.cnt - 1'b1;
        end
        // clocks per mode
        if (st_ff.ctrl[SPCG_BIT_POWER_RED])
        begin
            nxt_st.txdiv = '0;
            nxt_st.rxstate = '0;
        end
        else if (mode == SPCG_MODE_SLAVE)
        begin
            clk_rise = ext_rise;
            clk_fall = ext_fall;
            nxt_st.txclk = ext_rise | ext_fall;
            nxt_st.rxclk = ext_rise | ext_fall;
        end
        else if (gen_pulse)
        begin
            nxt_st.rxclk = 1'b1;
            nxt_st.rxstate = (st_ff.rxstate >= rx_last) ? 4'h0 : st_ff.rxstate + 4'h1;
            if (st_ff.txdiv >= tx_last)
            begin
                nxt_st.txdiv = 4'h0;
                nxt_st.txclk = 1'b1;
            end
            else
            begin
                nxt_st.txdiv = st_ff.txdiv + 4'h1;
            end
            if (mode == SPCG_MODE_MASTER)
            begin
                nxt_st.xck_out = ~st_ff.xck_out;
                clk_rise = !st_ff.xck_out;
                clk_fall = st_ff.xck_out;
            end
        end
        // pin drive only in master mode
        nxt_st.xck_oe = (mode == SPCG_MODE_MASTER)
            && !st_ff.ctrl[SPCG_BIT_POWER_RED];
        if (mode != SPCG_MODE_MASTER)
        begin
            nxt_st.xck_out = 1'b0;
        end
        if (mode == SPCG_MODE_MASTER || mode == SPCG_MODE_SLAVE)
        begin
            nxt_st.change_edge = st_ff.ctrl[SPCG_BIT_POLARITY] ? clk_fall : clk_rise;
            nxt_st.sample_edge = st_ff.ctrl[SPCG_BIT_POLARITY] ? clk_rise : clk_fall;
        end
        // apb slave, answer one cycle after access phase starts
        if (req.psel && req.penable && !st_ff.pready)
        begin
            nxt_st.pready = 1'b1;
            nxt_st.prdata = '0;
            if (req.paddr == SPCG_OFS_CTRL)
            begin
                nxt_st.prdata = {27'h000_0000, st_ff.ctrl};
            end
            else if (req.paddr == SPCG_OFS_DIV_LOW)
            begin
                nxt_st.prdata = {24'h00_0000, st_ff.div[7:0]};
            end
            else if (req.paddr == SPCG_OFS_DIV_HIGH)
            begin
                nxt_st.prdata = {28'h000_0000, st_ff.div[DIV_WIDTH-1:8]};
            end
            else if (req.paddr == SPCG_OFS_STATUS)
            begin
                nxt_st.prdata = {16'h0000, mode, st_ff.rxstate, st_ff.txdiv,
                    st_ff.xck_out, st_ff.xck_oe, st_ff.xsync[1], gen_pulse};
            end
            else
            begin
                nxt_st.pslverr = 1'b1;
            end
        end
        // writes land at the edge where the master sees pready
        if (req.psel && req.penable && req.pwrite && st_ff.pready)
        begin
            if (req.paddr == SPCG_OFS_CTRL)
            begin
                nxt_st.ctrl = req.pwdata[4:0];
            end
            else if (req.paddr == SPCG_OFS_DIV_LOW)
            begin
                nxt_st.div[7:0] = req.pwdata[7:0];
                nxt_st.cnt = {st_ff.div[DIV_WIDTH-1:8], req.pwdata[7:0]};
            end
            else if (req.paddr == SPCG_OFS_DIV_HIGH)
            begin
                nxt_st.div[DIV_WIDTH-1:8] = req.pwdata[3:0];
            end
        end
    end

    always_ff @(posedge I_CLK or negedge I_RST_N)
    begin
        if (!I_RST_N)
        begin
            st_ff <= '0;
            st_ff.ctrl <= SPCG_CTRL_RST;
            st_ff.div <= SPCG_DIV_RST;
            st_ff.cnt <= SPCG_CNT_RST;
        end
        else
        begin
            st_ff <= nxt_st;
        end
    end

    assign O_PRDATA = st_ff.prdata;
    assign O_PREADY = st_ff.pready;
    assign O_PSLVERR = st_ff.pslverr;
    assign O_XCK_OUT = st_ff.xck_out;
    assign O_XCK_OE = st_ff.xck_oe;
    assign O_TXCLK = st_ff.txclk;
    assign O_RXCLK = st_ff.rxclk;
    assign O_CHANGE_EDGE = st_ff.change_edge;
    assign O_SAMPLE_EDGE = st_ff.sample_edge;

    AST_ASYNC_NO_PIN: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
        !st_ff.ctrl[SPCG_BIT_SYNC_SEL] |=> !O_XCK_OE)
        else $error("pin driven in async mode");
    AST_RELOAD_AT_ZERO: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
        (st_ff.cnt == '0 && !(req.psel && req.penable && req.pwrite))
        |=> st_ff.cnt == $past(st_ff.div))
        else $error("counter did not reload");
    AST_COUNT_DOWN: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
        (st_ff.cnt != '0 && !(req.psel && req.penable))
        |=> st_ff.cnt == $past(st_ff.cnt) - 1'b1)
        else $error("counter did not decrement");
    AST_SLAVE_NO_GEN: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
        mode == SPCG_MODE_SLAVE |-> !gen_pulse)
        else $error("generator active in slave mode");
    AST_DOUBLE_ASYNC_ONLY: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
        st_ff.ctrl[SPCG_BIT_SYNC_SEL] |-> mode != SPCG_MODE_DOUBLE)
        else $error("double speed used in sync mode");
    AST_TX_DIV_RANGE: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
        gen_pulse |=> st_ff.txdiv <= $past(tx_last))
        else $error("transmit divider out of range");

    AST_RX_EACH_PULSE: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
        gen_pulse |=> O_RXCLK)
        else $error("receiver tick missing");

    AST_POWER_QUIET: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
        st_ff.ctrl[SPCG_BIT_POWER_RED] |=> !O_TXCLK && !O_RXCLK)
        else $error("clocks run while power reduced");

    AST_LOW_WRITE_RELOAD: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
        (req.psel && req.penable && req.pwrite && st_ff.pready
         && req.paddr == SPCG_OFS_DIV_LOW) |=> st_ff.cnt[7:0] == $past(req.pwdata[7:0]))
        else $error("low write did not reload counter");

    AST_HIGH_WRITE: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
        (req.psel && req.penable && req.pwrite && st_ff.pready
         && req.paddr == SPCG_OFS_DIV_HIGH) |=> st_ff.div[11:8] == $past(req.pwdata[3:0]))
        else $error("high divisor bits not written");

    AST_SLAVE_NO_DRIVE: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
        mode == SPCG_MODE_SLAVE |=> !O_XCK_OE)
        else $error("pin driven in slave mode");

    AST_ASYNC_NO_EDGES: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
        !st_ff.ctrl[SPCG_BIT_SYNC_SEL] |=> !O_CHANGE_EDGE && !O_SAMPLE_EDGE)
        else $error("data edges in async mode");

    AST_MASTER_CHANGE_RISE: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
        (mode == SPCG_MODE_MASTER && gen_pulse && !st_ff.ctrl[SPCG_BIT_POLARITY]
         && !st_ff.xck_out) |=> O_CHANGE_EDGE && !O_SAMPLE_EDGE)
        else $error("change edge not on rising clock");
    AST_MASTER_TOGGLE: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
        (mode == SPCG_MODE_MASTER && gen_pulse && $stable(mode))
        |=> O_XCK_OUT != $past(O_XCK_OUT))
        else $error("master clock did not toggle");
    AST_SLAVE_EDGE: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
        (mode == SPCG_MODE_SLAVE && $stable(mode) && !st_ff.ctrl[SPCG_BIT_POWER_RED]
         && (ext_rise || ext_fall)) |=> O_TXCLK && O_RXCLK)
        else $error("slave edge not passed on");
endmodule
`default_nettype wire

/* core/spcg_pkg.sv */
/*
 serial port clock generator package: register offsets, field positions,
 reset values, mode encodings and the bus request carrier.
 assumes an apb slave of 32-bit data on a 200 MHz clock.
*/
`default_nettype none
package spcg_pkg;
    localparam logic [7:0] SPCG_OFS_CTRL = 8'h00;
    localparam logic [7:0] SPCG_OFS_DIV_LOW = 8'h04;
    localparam logic [7:0] SPCG_OFS_DIV_HIGH = 8'h08;
    localparam logic [7:0] SPCG_OFS_STATUS = 8'h0C;
    localparam int SPCG_BIT_SYNC_SEL = 0;
    localparam int SPCG_BIT_DOUBLE = 1;
    localparam int SPCG_BIT_PIN_DIR = 2;
    localparam int SPCG_BIT_POLARITY = 3;
    localparam int SPCG_BIT_POWER_RED = 4;
    localparam logic [4:0] SPCG_CTRL_RST = 5'h10;
    localparam logic [11:0] SPCG_DIV_RST = 12'h000;
    localparam logic [11:0] SPCG_CNT_RST = 12'h000;
    localparam int SPCG_SYNC_STAGES = 2;
    localparam int SPCG_DIV_NORMAL = 16;
    localparam int SPCG_DIV_DOUBLE = 8;
    localparam int SPCG_DIV_SYNC = 2;

    typedef enum logic [3:0] {
        SPCG_MODE_ASYNC = 4'b0001,
        SPCG_MODE_DOUBLE = 4'b0010,
        SPCG_MODE_MASTER = 4'b0100,
        SPCG_MODE_SLAVE = 4'b1000
    } spcg_mode_t;

    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [7:0] paddr;
        logic [31:0] pwdata;
    } spcg_apb_req_t;
endpackage
`default_nettype wire

/* tb/spcg_clock_gen_tb.sv */
/*
 bench of the clock generator: register access, mode periods, slave clock.
 assumes the partner drives the pin whenever the block does not.
*/
`default_nettype none
module spcg_clock_gen_tb
    import spcg_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic start = 1'b0;
    spcg_apb_req_t req = '0;
    logic [31:0] prdata, rd;
    logic pready, pslverr, err, xo, oe, txclk, rxclk, chg, smp, p_xck, pin, lvl;
    int mismatches = 0;
    int samples_checked = 0;
    int n_rx = 0;
    int n_chg = 0;
    int n_smp = 0;
    always #2.5 clk = ~clk;
    assign pin = oe ? xo : p_xck;
    always @(posedge clk)
    begin
        n_rx <= n_rx + int'(rxclk);
        n_chg <= n_chg + int'(chg);
        n_smp <= n_smp + int'(smp);
        if (chg)
            lvl <= pin;
    end
    spcg_clock_gen i_spcg_clock_gen (.I_CLK(clk), .I_RST_N(rst_n), .I_PSEL(req.psel),
        .I_PENABLE(req.penable), .I_PWRITE(req.pwrite), .I_PADDR(req.paddr),
        .I_PWDATA(req.pwdata), .O_PRDATA(prdata), .O_PREADY(pready), .O_PSLVERR(pslverr),
        .I_XCK_IN(pin), .O_XCK_OUT(xo), .O_XCK_OE(oe), .O_TXCLK(txclk), .O_RXCLK(rxclk),
        .O_CHANGE_EDGE(chg), .O_SAMPLE_EDGE(smp));
    spcg_xfer_partner i_spcg_xfer_partner (.i_clk(clk), .i_start(start), .o_xck(p_xck));
    task automatic final_report();
        $display("checked %0d mismatches %0d", samples_checked, mismatches);
        if (mismatches == 0 && samples_checked > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        samples_checked++;
        if (g !== e)
        begin
            mismatches++;
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int k;
        @(posedge clk);
        req <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: a, pwdata: d};
        @(posedge clk);
        req.penable <= 1'b1;
        for (k = 0; k < 20 && pready !== 1'b1; k++)
            @(posedge clk);
        rd = prdata;
        err = pslverr;
        req.psel <= 1'b0;
        req.penable <= 1'b0;
        if (k == 20)
        begin
            chk("pready", 32'h0000_0001, 32'h0000_0000);
            final_report();
        end
    endtask
    function automatic logic pulse(input int w);
        return (w == 0) ? rxclk : txclk;
    endfunction
    task automatic per(input int w, input int e, input string nm);
        int n;
        int k;
        n = -1;
        for (k = 0; k < 10000; k++)
        begin
            @(posedge clk);
            if (pulse(w) === 1'b1 && n >= 0)
                break;
            n = (pulse(w) === 1'b1) ? 0 : ((n >= 0) ? n + 1 : n);
        end
        if (k == 10000)
        begin
            chk("period timeout", 32'h0000_0001, 32'h0000_0000);
            final_report();
        end
        chk(nm, e, 32'(n + 1));
    endtask
    task automatic t_reset();
        int n0;
        apb(1'b0, SPCG_OFS_CTRL, 32'h0000_0000);
        chk("ctrl", 32'h0000_0010, rd);
        apb(1'b0, SPCG_OFS_DIV_LOW, 32'h0000_0000);
        chk("div low", 32'h0000_0000, rd);
        apb(1'b1, 8'h10, 32'h0000_0001);
        chk("slverr", 32'h0000_0001, 32'(err));
        n0 = n_rx;
        repeat (40) @(posedge clk);
        chk("rx held", 32'(n0), 32'(n_rx));
    endtask
    task automatic t_async();
        apb(1'b1, SPCG_OFS_DIV_LOW, 32'h0000_0003);
        apb(1'b1, SPCG_OFS_CTRL, 32'h0000_0000);
        per(0, 4, "rx period");
        per(1, 64, "tx normal");
        chk("oe async", 32'h0000_0000, 32'(oe));
        apb(1'b1, SPCG_OFS_CTRL, 32'h0000_0002);
        per(1, 32, "tx double");
        apb(1'b1, SPCG_OFS_CTRL, 32'h0000_0005);
        per(1, 8, "tx master");
        chk("oe master", 32'h0000_0001, 32'(oe));
        apb(1'b0, SPCG_OFS_STATUS, 32'h0000_0000);
        chk("status mode", 32'h0000_0004, 32'(rd[15:12]));
        chk("status oe", 32'h0000_0001, 32'(rd[2]));
    endtask
    task automatic t_div();
        apb(1'b1, SPCG_OFS_CTRL, 32'h0000_0000);
        apb(1'b1, SPCG_OFS_DIV_HIGH, 32'h0000_000F);
        apb(1'b1, SPCG_OFS_DIV_LOW, 32'h0000_00FF);
        apb(1'b0, SPCG_OFS_DIV_HIGH, 32'h0000_0000);
        chk("div high", 32'h0000_000F, rd);
        per(0, 4096, "rx max div");
        apb(1'b1, SPCG_OFS_DIV_HIGH, 32'h0000_0001);
        apb(1'b1, SPCG_OFS_DIV_LOW, 32'h0000_0000);
        per(0, 257, "rx div 256");
    endtask
    task automatic t_slave(input logic pol);
        int c0;
        int s0;
        apb(1'b1, SPCG_OFS_CTRL, {28'h000_0000, pol, 3'b001});
        repeat (3) @(posedge clk);
        chk("oe slave", 32'h0000_0000, 32'(oe));
        c0 = n_chg;
        s0 = n_smp;
        start <= 1'b1;
        @(posedge clk);
        start <= 1'b0;
        repeat (80) @(posedge clk);
        chk("change count", 32'h0000_0004, 32'(n_chg - c0));
        chk("sample count", 32'h0000_0004, 32'(n_smp - s0));
        chk("change level", 32'(!pol), 32'(lvl));
    endtask
    initial
    begin
        repeat (4) @(posedge clk);
        rst_n <= 1'b1;
        t_reset();
        t_async();
        t_div();
        t_slave(1'b0);
        t_slave(1'b1);
        final_report();
    end
endmodule
`default_nettype wire

/* tb/spcg_xfer_partner.sv */
/*
 remote transceiver model: drives the transfer clock pin in slave mode.
 assumes the bench pulses i_start once per burst of EDGES toggles.
*/
`default_nettype none
module spcg_xfer_partner #(
    parameter int HALF = 8,
    parameter int EDGES = 8
)
(
    input wire logic i_clk,
    input wire logic i_start,
    output logic o_xck
);
    timeunit 1ns;
    timeprecision 100ps;
    int left = 0;
    int cnt = 0;
    initial o_xck = 1'b0;
    // clock stands still low between bursts, half period well above two cycles
    always @(posedge i_clk)
    begin
        if (i_start)
        begin
            left <= EDGES;
            cnt <= 0;
        end
        else if (left > 0)
        begin
            cnt <= (cnt == HALF - 1) ? 0 : cnt + 1;
            if (cnt == HALF - 1)
            begin
                o_xck <= ~o_xck;
                left <= left - 1;
            end
        end
    end
endmodule
`default_nettype wire
